// >>> design/sdb_params.svh
// Constants of the serial port control and data buffer block
// Functional notes
// - 9-bit filtered: accept only ninth bit 1
// - 9-bit unfiltered: ninth bit level ignored
// - Bit 4 receive enable gates reception
// - Bit 3 sent as ninth bit
// - Bit 2 gets stop or ninth bit
// - Transmit done at stop bit start
// - Done flags cleared only by software
// - Receive done set at stop sampling
// - Receive done requests interrupt when enabled
// - Data buffer: write shifter, read latch
// - Data write starts transmission at once
// - Data read leaves transmit shifter alone
// - Nine-bit frame: eleven bits, LSB first
// - Bit 7 selects 8 or 9-bit frames
// - Accept only while receive done clear
// - 8-bit filtered: stop bit must be 1
`ifndef SDB_PARAMS_SVH
`define SDB_PARAMS_SVH
`define SDB_AW 12
`define SDB_IDX_CTRL 10'h098
`define SDB_IDX_DATA 10'h099
`define SDB_IDX_STAT 10'h09A
`define SDB_IDX_MASK 10'h09B
`define SDB_CTRL_RST 8'h40
`define SDB_DATA_RST 8'h00
`define SDB_B_MODE 7
`define SDB_B_MCE 5
`define SDB_B_REN 4
`define SDB_B_TB8 3
`define SDB_B_RB8 2
`define SDB_B_TI 1
`define SDB_B_RI 0
`define SDB_M_IE 2
`define SDB_E_TX 0
`define SDB_E_RX 1
`define SDB_OVS 16
`define SDB_LAST_BIT 3'h7
`define SDB_RESP_OK 2'h0
`define SDB_RESP_ERR 2'h2
`endif

// >>> design/sdb_pkg.sv
// Types of the serial port control and data buffer block
package sdb_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINE, TX_STOP} sdb_tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINE, RX_STOP} sdb_rx_st_t;
endpackage : sdb_pkg

// >>> design/sdb_uart.sv
// Serial port control, data buffer, shifters and AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sdb_params.svh"
module sdb_uart #(
   parameter int OVS = `SDB_OVS
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [`SDB_AW-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [`SDB_AW-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic BAUD_TICK,
   input wire logic RXD,
   output logic TXD,
   output logic IRQ
);
   import sdb_pkg::*;

   localparam logic [7:0] LAST = 8'(OVS - 1);
   localparam logic [7:0] HALF = 8'(OVS / 2 - 1);
   // Named copy so single reset bits can be selected
   localparam logic [7:0] CTRL_RST = `SDB_CTRL_RST;

   ////////////////////////////////////////////////////////////////
   logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r, txd_r;
   logic [`SDB_AW-1:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic mode_r, mce_r, ren_r, tb8_r, rb8_r, ti_r, ri_r;
   logic [7:0] rx_buf_r, tx_shift_r, rx_shift_r;
   logic [1:0] evt_r;
   logic [2:0] mask_r;
   sdb_tx_st_t tx_st_r;
   sdb_rx_st_t rx_st_r;
   logic [7:0] tx_cnt_r, rx_cnt_r;
   logic [2:0] tx_bit_r, rx_bit_r;
   logic rx_b9_r;

   logic wr_go, rd_go, wr_ok;
   logic wr_ctrl, wr_data, wr_mask, rd_stat;
   logic [9:0] wr_idx, rd_idx;
   logic tx_last, rx_last, rx_mid;
   logic to_stop, to_nine, stop_smp, accept, ti_set, ri_set, rb8_val;

   ////////////////////////////////////////////////////////////////
   // Bus slave
   assign AWREADY = !aw_hold_r && !bvalid_r;
   assign WREADY = !w_hold_r && !bvalid_r;
   assign ARREADY = !rvalid_r;
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign RVALID = rvalid_r;
   assign RDATA = rdata_r;
   assign RRESP = rresp_r;

   assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
   assign rd_go = ARVALID && !rvalid_r;
   assign wr_idx = aw_addr_r[`SDB_AW-1:2];
   assign rd_idx = ARADDR[`SDB_AW-1:2];
   assign wr_ok = wr_go && w_lane_r;
   assign wr_ctrl = wr_ok && wr_idx == `SDB_IDX_CTRL;
   assign wr_data = wr_ok && wr_idx == `SDB_IDX_DATA;
   assign wr_mask = wr_ok && wr_idx == `SDB_IDX_MASK;
   assign rd_stat = rd_go && rd_idx == `SDB_IDX_STAT;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (AWVALID && AWREADY) begin
         aw_hold_r <= 1'b1;
         aw_addr_r <= AWADDR;
      end else if (wr_go) begin
         aw_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         w_hold_r <= 1'b0;
         w_data_r <= '0;
         w_lane_r <= 1'b0;
      end else if (WVALID && WREADY) begin
         w_hold_r <= 1'b1;
         w_data_r <= WDATA[7:0];
         w_lane_r <= WSTRB[0];
      end else if (wr_go) begin
         w_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         bvalid_r <= 1'b0;
         bresp_r <= `SDB_RESP_OK;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         case (wr_idx)
            `SDB_IDX_CTRL, `SDB_IDX_DATA, `SDB_IDX_STAT, `SDB_IDX_MASK:
               bresp_r <= `SDB_RESP_OK;
            default: bresp_r <= `SDB_RESP_ERR;
         endcase
      end else if (BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // Data reads return the receive latch only
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `SDB_RESP_OK;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r <= `SDB_RESP_OK;
         case (rd_idx)
            `SDB_IDX_CTRL: rdata_r <= {24'h0, mode_r, 1'b1, mce_r, ren_r,
                                       tb8_r, rb8_r, ti_r, ri_r};
            `SDB_IDX_DATA: rdata_r <= {24'h0, rx_buf_r};
            `SDB_IDX_STAT: rdata_r <= {30'h0, evt_r};
            `SDB_IDX_MASK: rdata_r <= {29'h0, mask_r};
            default: begin
               rdata_r <= '0;
               rresp_r <= `SDB_RESP_ERR;
            end
         endcase
      end else if (RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control register fields
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         mode_r <= CTRL_RST[`SDB_B_MODE];
         mce_r <= CTRL_RST[`SDB_B_MCE];
         ren_r <= CTRL_RST[`SDB_B_REN];
         tb8_r <= CTRL_RST[`SDB_B_TB8];
      end else if (wr_ctrl) begin
         mode_r <= w_data_r[`SDB_B_MODE];
         mce_r <= w_data_r[`SDB_B_MCE];
         ren_r <= w_data_r[`SDB_B_REN];
         tb8_r <= w_data_r[`SDB_B_TB8];
      end
   end

   // Hardware only sets; a set in the cycle of a clearing write wins
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ti_r <= CTRL_RST[`SDB_B_TI];
      end else if (ti_set) begin
         ti_r <= 1'b1;
      end else if (wr_ctrl) begin
         ti_r <= w_data_r[`SDB_B_TI];
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ri_r <= CTRL_RST[`SDB_B_RI];
      end else if (ri_set) begin
         ri_r <= 1'b1;
      end else if (wr_ctrl) begin
         ri_r <= w_data_r[`SDB_B_RI];
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rb8_r <= CTRL_RST[`SDB_B_RB8];
         rx_buf_r <= `SDB_DATA_RST;
      end else if (ri_set) begin
         rb8_r <= rb8_val;
         rx_buf_r <= rx_shift_r;
      end else if (wr_ctrl) begin
         rb8_r <= w_data_r[`SDB_B_RB8];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Event status, mask and interrupt
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         evt_r <= '0;
      end else begin
         evt_r[`SDB_E_TX] <= ti_set || (evt_r[`SDB_E_TX] && !rd_stat);
         evt_r[`SDB_E_RX] <= ri_set || (evt_r[`SDB_E_RX] && !rd_stat);
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= w_data_r[2:0];
      end
   end

   // Port enable follows the flags; mask bits follow sticky events
   assign IRQ = (mask_r[`SDB_M_IE] && (ti_r || ri_r))
                || |(evt_r & mask_r[1:0]);

   ////////////////////////////////////////////////////////////////
   // Transmitter; a write while busy restarts the frame
   assign tx_last = BAUD_TICK && tx_cnt_r == LAST;
   assign to_stop = tx_last && ((tx_st_r == TX_DATA && tx_bit_r == `SDB_LAST_BIT
                    && !mode_r) || tx_st_r == TX_NINE);
   assign to_nine = tx_last && tx_st_r == TX_DATA && tx_bit_r == `SDB_LAST_BIT
                    && mode_r;
   assign ti_set = to_stop;
   assign TXD = txd_r;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         tx_st_r <= TX_IDLE;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         tx_shift_r <= `SDB_DATA_RST;
         txd_r <= 1'b1;
      end else if (wr_data) begin
         tx_st_r <= TX_START;
         tx_shift_r <= w_data_r;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         txd_r <= 1'b0;
      end else if (tx_st_r != TX_IDLE && BAUD_TICK) begin
         tx_cnt_r <= tx_last ? 8'h00 : tx_cnt_r + 8'h01;
         if (tx_last) begin
            case (tx_st_r)
               TX_START: begin
                  tx_st_r <= TX_DATA;
                  txd_r <= tx_shift_r[0];
               end
               TX_DATA: begin
                  if (tx_bit_r == `SDB_LAST_BIT) begin
                     tx_st_r <= mode_r ? TX_NINE : TX_STOP;
                     txd_r <= mode_r ? tb8_r : 1'b1;
                  end else begin
                     tx_bit_r <= tx_bit_r + 3'h1;
                     txd_r <= tx_shift_r[tx_bit_r + 3'h1];
                  end
               end
               TX_NINE: begin
                  tx_st_r <= TX_STOP;
                  txd_r <= 1'b1;
               end
               TX_STOP: tx_st_r <= TX_IDLE;
               default: tx_st_r <= TX_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Receiver, sampling at mid-bit
   assign rx_last = BAUD_TICK && rx_cnt_r == LAST;
   assign rx_mid = BAUD_TICK && rx_cnt_r == HALF;
   assign stop_smp = rx_last && rx_st_r == RX_STOP && ren_r;
   assign rb8_val = mode_r ? rx_b9_r : RXD;
   // Filter: 9-bit needs ninth bit 1, 8-bit needs stop bit 1
   assign accept = !ri_r && (!mce_r || rb8_val);
   assign ri_set = stop_smp && accept;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_shift_r <= '0;
         rx_b9_r <= 1'b0;
      end else if (!ren_r) begin
         rx_st_r <= RX_IDLE;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               rx_cnt_r <= '0;
               if (!RXD) begin
                  rx_st_r <= RX_START;
               end
            end
            RX_START: begin
               if (BAUD_TICK) begin
                  rx_cnt_r <= rx_cnt_r + 8'h01;
               end
               // Glitch shorter than half a bit is dropped
               if (rx_mid) begin
                  rx_cnt_r <= '0;
                  rx_bit_r <= '0;
                  rx_st_r <= RXD ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA, RX_NINE, RX_STOP: begin
               if (BAUD_TICK) begin
                  rx_cnt_r <= rx_last ? 8'h00 : rx_cnt_r + 8'h01;
               end
               if (rx_last) begin
                  case (rx_st_r)
                     RX_DATA: begin
                        rx_shift_r <= {RXD, rx_shift_r[7:1]};
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == `SDB_LAST_BIT) begin
                           rx_st_r <= mode_r ? RX_NINE : RX_STOP;
                        end
                     end
                     RX_NINE: begin
                        rx_b9_r <= RXD;
                        rx_st_r <= RX_STOP;
                     end
                     default: rx_st_r <= RX_IDLE;
                  endcase
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_ri_set;
      @(posedge CLK) disable iff (RESET) ri_set |=> ri_r && rx_buf_r == $past(rx_shift_r);
   endproperty
   a_ri_set: assert property (p_ri_set) else $error("receive done not set");

   property p_ri_hold;
      @(posedge CLK) disable iff (RESET) (stop_smp && ri_r) |=> $stable(rx_buf_r);
   endproperty
   a_ri_hold: assert property (p_ri_hold) else $error("latch overwritten");

   property p_filter9;
      @(posedge CLK) disable iff (RESET)
         (stop_smp && mode_r && mce_r && !rx_b9_r) |-> !ri_set;
   endproperty
   a_filter9: assert property (p_filter9) else $error("filtered frame taken");

   property p_ren;
      @(posedge CLK) disable iff (RESET) !ren_r |=> rx_st_r == RX_IDLE;
   endproperty
   a_ren: assert property (p_ren) else $error("receiving while disabled");

   property p_ninth;
      @(posedge CLK) disable iff (RESET) (to_nine && !wr_data) |=> TXD == $past(tb8_r);
   endproperty
   a_ninth: assert property (p_ninth) else $error("wrong ninth bit");

   property p_ti;
      @(posedge CLK) disable iff (RESET) (to_stop && !wr_data) |=> ti_r && TXD;
   endproperty
   a_ti: assert property (p_ti) else $error("transmit done missing");

   property p_keep;
      @(posedge CLK) disable iff (RESET) !wr_ctrl |=> !$fell(ti_r) && !$fell(ri_r);
   endproperty
   a_keep: assert property (p_keep) else $error("flag cleared by hardware");

   property p_start;
      @(posedge CLK) disable iff (RESET) wr_data |=> tx_st_r == TX_START && !TXD;
   endproperty
   a_start: assert property (p_start) else $error("write did not start");

   property p_rb8;
      @(posedge CLK) disable iff (RESET) ri_set |=> rb8_r == $past(rb8_val);
   endproperty
   a_rb8: assert property (p_rb8) else $error("ninth receive bit wrong");

   property p_irq;
      @(posedge CLK) disable iff (RESET) (mask_r[`SDB_M_IE] && (ti_r || ri_r)) |-> IRQ;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule : sdb_uart
`default_nettype wire

// >>> testbench/sdb_node.sv
// Remote serial node model facing the receive and transmit lines
`timescale 1ns/1ps
`default_nettype none
module sdb_node #(
   parameter int OVS = 4
) (
   input wire logic CLK,
   input wire logic BAUD_TICK,
   input wire logic TXD,
   output logic RXD
);
   logic [9:0] got = '0;
   int idx = 0;
   int frames = 0;
   initial begin
      RXD = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge CLK iff BAUD_TICK);
   endtask : tick
   // Start bit, n bits LSB first, then idle high; bit n-1 is the stop level
   task automatic send(input logic [9:0] bits, input int n);
      @(posedge CLK);
      RXD <= 1'b0;
      tick(OVS);
      for (int i = 0; i < n; i++) begin
         RXD <= bits[i];
         tick(OVS);
      end
      RXD <= 1'b1;
      tick(OVS);
   endtask : send
   // Mid-bit sampling; ten samples cover both frame lengths
   always begin
      @(negedge TXD);
      idx = 0;
      tick(OVS / 2);
      for (int i = 0; i < 10; i++) begin
         tick(OVS);
         got[i] = TXD;
         idx = i + 1;
      end
      frames++;
   end
endmodule : sdb_node
`default_nettype wire

// >>> testbench/test_sdb_uart.sv
// Self-checking bench of the serial port control and data buffer
`timescale 1ns/1ps
`default_nettype none
`include "sdb_params.svh"
module test_sdb_uart;
   localparam int OVS = 4;
   localparam logic [11:0] A_C = {`SDB_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_D = {`SDB_IDX_DATA, 2'b00};
   localparam logic [11:0] A_S = {`SDB_IDX_STAT, 2'b00};
   localparam logic [11:0] A_M = {`SDB_IDX_MASK, 2'b00};
   logic CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY, BAUD_TICK, RXD;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXD, IRQ;
   logic [11:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   int fail_count = 0;
   int comparisons = 0;
   sdb_uart #(.OVS(OVS)) dut_u (.CLK(CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .BAUD_TICK(BAUD_TICK), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
   sdb_node #(.OVS(OVS)) node_u (.CLK(CLK), .BAUD_TICK(BAUD_TICK), .TXD(TXD), .RXD(RXD));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // Tick every other cycle keeps frames short
   always @(posedge CLK) BAUD_TICK <= RESET ? 1'b0 : ~BAUD_TICK;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("counts: %0d mismatches, %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // Ready is sampled at the negedge so the decision never races the edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic pa, pw, ta, tw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (pa || pw) begin
         @(negedge CLK);
         ta = AWREADY;
         tw = WREADY;
         @(posedge CLK);
         if (pa && ta) begin
            AWVALID <= 1'b0;
            pa = 1'b0;
         end
         if (pw && tw) begin
            WVALID <= 1'b0;
            pw = 1'b0;
         end
      end
      do @(negedge CLK); while (BVALID !== 1'b1);
      chk(BRESP, er);
      @(posedge CLK);
      BREADY <= 1'b0;
      @(negedge CLK);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(negedge CLK); while (ARREADY !== 1'b1);
      @(posedge CLK);
      ARVALID <= 1'b0;
      do @(negedge CLK); while (RVALID !== 1'b1);
      chk(RRESP, er);
      chk(RDATA, {24'h0, e});
      @(posedge CLK);
      RREADY <= 1'b0;
      @(negedge CLK);
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(A_C, 8'h40, 2'h0);
      rd(A_D, 8'h00, 2'h0);
      rd(A_S, 8'h00, 2'h0);
      rd(A_M, 8'h00, 2'h0);
      rd(12'h3F0, 8'h00, 2'h2);
      wr(12'h3F0, 8'hFF, 2'h0 | 2'h2);
      wr(A_C, 8'h2C, 2'h0);
      rd(A_C, 8'h6C, 2'h0);
      wr(A_C, 8'h00, 2'h0);
      wr(A_M, 8'h07, 2'h0);
      rd(A_M, 8'h07, 2'h0);
      $display("register test done");
   endtask : t_regs
   task automatic t_tx_one(input logic [7:0] c, input logic [7:0] d, input logic [9:0] ef,
                           input int ni);
      int f;
      f = node_u.frames;
      wr(A_C, c, 2'h0);
      wr(A_D, d, 2'h0);
      chk(TXD, 1'b0);
      rd(A_D, 8'h00, 2'h0);
      do @(negedge CLK); while (IRQ !== 1'b1);
      chk(TXD, 1'b1);
      chk(node_u.idx, ni);
      wait (node_u.frames != f);
      chk(node_u.got, ef);
      rd(A_C, c | 8'h42, 2'h0);
      rd(A_S, 8'h01, 2'h0);
      rd(A_S, 8'h00, 2'h0);
      wr(A_C, c, 2'h0);
      chk(IRQ, 1'b0);
   endtask : t_tx_one
   task automatic t_tx();
      wr(A_M, 8'h04, 2'h0);
      t_tx_one(8'h00, 8'hA5, 10'h3A5, 8);
      t_tx_one(8'h88, 8'h3C, 10'h33C, 9);
      t_tx_one(8'h80, 8'hC3, 10'h2C3, 9);
      $display("transmit test done");
   endtask : t_tx
   // Clearing receive enable at the end aborts a false start after a low stop bit
   task automatic t_rx_one(input logic [7:0] c, input logic [9:0] b, input int n,
                           input logic [7:0] ec, input logic [7:0] ed);
      wr(A_C, c, 2'h0);
      node_u.send(b, n);
      rd(A_C, ec, 2'h0);
      rd(A_D, ed, 2'h0);
      chk(IRQ, ec[0]);
      wr(A_C, 8'h00, 2'h0);
   endtask : t_rx_one
   task automatic t_rx();
      t_rx_one(8'h00, 10'h111, 9, 8'h40, 8'h00);
      t_rx_one(8'h10, 10'h15A, 9, 8'h55, 8'h5A);
      t_rx_one(8'h11, 10'h1AA, 9, 8'h51, 8'h5A);
      t_rx_one(8'h30, 10'h077, 9, 8'h70, 8'h5A);
      t_rx_one(8'h30, 10'h177, 9, 8'h75, 8'h77);
      t_rx_one(8'h10, 10'h066, 9, 8'h51, 8'h66);
      t_rx_one(8'hB0, 10'h299, 10, 8'hF0, 8'h66);
      t_rx_one(8'hB0, 10'h3C6, 10, 8'hF5, 8'hC6);
      t_rx_one(8'h90, 10'h224, 10, 8'hD1, 8'h24);
      $display("receive test done");
   endtask : t_rx
   task automatic t_irq();
      rd(A_S, 8'h02, 2'h0);
      rd(A_S, 8'h00, 2'h0);
      wr(A_M, 8'h02, 2'h0);
      t_rx_one(8'h10, 10'h1A5, 9, 8'h55, 8'hA5);
      chk(IRQ, 1'b1);
      rd(A_S, 8'h02, 2'h0);
      chk(IRQ, 1'b0);
      // Transmit event through its own mask bit, port enable off
      wr(A_M, 8'h01, 2'h0);
      wr(A_D, 8'h5A, 2'h0);
      do @(negedge CLK); while (IRQ !== 1'b1);
      chk(TXD, 1'b1);
      rd(A_C, 8'h42, 2'h0);
      rd(A_S, 8'h01, 2'h0);
      chk(IRQ, 1'b0);
      $display("interrupt test done");
   endtask : t_irq
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      stop_test();
   end
   initial begin
      RESET = 1'b1;
      AWADDR = '0;
      ARADDR = '0;
      WDATA = '0;
      WSTRB = 4'hF;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      BREADY = 1'b0;
      ARVALID = 1'b0;
      RREADY = 1'b0;
      repeat (16) @(posedge CLK);
      RESET <= 1'b0;
      t_regs();
      t_tx();
      t_rx();
      t_irq();
      stop_test();
   end
endmodule : test_sdb_uart
`default_nettype wire
